/* hw/asbs_top.sv */
// Purpose: Baud divisor, status and option registers of a serial port on APB.
// Assumes: Single clock pclk; rxd_pin is asynchronous.
// Notes: APB answers with zero wait states.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "asbs_cfg.svh"
module asbs_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic rxd_pin,
   output logic txd_pin
);
   asbs_pkg::asbs_top_state_t s;
   asbs_pkg::asbs_top_state_t next_s;
   asbs_if link ();

   function automatic logic asbs_mapped(input logic [7:0] a);
      asbs_mapped = (a[1:0] == 2'b00) && (a <= `ASBS_OFS_IRQ_MASK);
   endfunction

   asbs_rx u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .bus(link.rx)
   );

   // ==========================================================
   // Connections to the receiver
   assign link.tick = s.tick;
   assign link.rxd = s.sync2 ^ s.receive_invert;
   assign link.rx_on = s.ctrl[`ASBS_BIT_RX_ON];
   assign link.parity_on = s.ctrl[`ASBS_BIT_PARITY_ON];
   assign link.nine_bit = s.ctrl[`ASBS_BIT_NINE_BIT];

   // ==========================================================
   // Next state
   always_comb begin
      logic setup;
      logic access;
      logic wr;
      logic rd;
      logic [7:0] wb;
      logic [31:0] rdv;
      logic edge_ev;
      logic brk_ev;
      logic idle_ev;
      logic [5:0] ev;
      logic [3:0] blen;
      next_s = s;
      setup = psel && !penable;
      access = psel && penable && s.pready;
      wr = access && pwrite && asbs_mapped(paddr);
      rd = access && !pwrite && asbs_mapped(paddr);
      wb = pwdata[7:0];
      rdv = 32'h0000_0000;
      {edge_ev, brk_ev, idle_ev, ev, blen} = '0;
      next_s.sync1 = rxd_pin;
      next_s.sync2 = s.sync1;
      next_s.prev_rx = s.sync2;
      next_s.tick = 1'b0;
      // Baud generator.
      if (s.ctrl[`ASBS_BIT_RX_ON] || s.ctrl[`ASBS_BIT_TX_ON]) begin
         next_s.gen_armed = 1'b1;
      end
      if (s.baud_divisor == 13'h0000 || !s.gen_armed) begin
         next_s.div_cnt = 13'h0000;
      end else if (s.div_cnt >= s.baud_divisor - 13'h0001) begin
         next_s.div_cnt = 13'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 13'h0001;
      end
      // Receive events.
      // Edges are taken from the pin itself, so a change of the invert bit raises no edge flag.
      edge_ev = s.receive_invert ? (!s.prev_rx && s.sync2) : (s.prev_rx && !s.sync2);
      brk_ev = link.done && link.brk && s.ctrl[`ASBS_BIT_BREAK_DET];
      idle_ev = link.idle && (!s.ctrl[`ASBS_BIT_WAKE_STANDBY] || s.wake_idle_select);
      // Software side effects.
      if (rd && paddr == `ASBS_OFS_STATUS1 && (s.rx_full_flag || s.framing_error_flag ||
          s.parity_error_flag || s.idle_flag)) begin
         next_s.clear_armed = 1'b1;
      end
      if (rd && paddr == `ASBS_OFS_DATA && s.clear_armed) begin
         next_s.clear_armed = 1'b0;
         next_s.rx_full_flag = 1'b0;
         next_s.framing_error_flag = 1'b0;
         next_s.parity_error_flag = 1'b0;
         next_s.idle_flag = 1'b0;
      end
      if (wr) begin
         case (paddr)
            `ASBS_OFS_BAUD_UPPER: begin
               next_s.break_irq_enable = wb[`ASBS_BIT_BREAK_IE];
               next_s.edge_irq_enable = wb[`ASBS_BIT_EDGE_IE];
               next_s.baud_upper_buf = wb[4:0];
            end
            `ASBS_OFS_BAUD_LOWER: begin
               next_s.baud_divisor = {s.baud_upper_buf, wb};
            end
            `ASBS_OFS_STATUS2: begin
               if (wb[`ASBS_BIT_BREAK_FLAG]) begin
                  next_s.break_flag = 1'b0;
               end
               if (wb[`ASBS_BIT_EDGE_FLAG]) begin
                  next_s.edge_flag = 1'b0;
               end
               next_s.receive_invert = wb[`ASBS_BIT_RX_INVERT];
               next_s.wake_idle_select = wb[`ASBS_BIT_WAKE_IDLE];
               next_s.long_break_select = wb[`ASBS_BIT_LONG_BREAK];
            end
            `ASBS_OFS_CONTROL: begin
               next_s.ctrl = wb[6:0];
            end
            `ASBS_OFS_IRQ_STATUS: begin
               next_s.irq_status = s.irq_status & ~wb[5:0];
            end
            `ASBS_OFS_IRQ_MASK: begin
               next_s.irq_mask = wb[5:0];
            end
            default: begin
               next_s.irq_mask = s.irq_mask;
            end
         endcase
      end
      // Hardware sets win over clears in the same cycle.
      if (link.done && !s.ctrl[`ASBS_BIT_WAKE_STANDBY]) begin
         next_s.rx_full_flag = 1'b1;
         next_s.rx_data = link.data;
         next_s.framing_error_flag = link.fe;
         next_s.parity_error_flag = link.pe;
      end
      if (link.idle && s.ctrl[`ASBS_BIT_WAKE_STANDBY]) begin
         next_s.ctrl[`ASBS_BIT_WAKE_STANDBY] = 1'b0;
      end
      if (idle_ev) begin
         next_s.idle_flag = 1'b1;
      end
      if (brk_ev) begin
         next_s.break_flag = 1'b1;
      end
      if (edge_ev) begin
         next_s.edge_flag = 1'b1;
      end
      ev = {link.done && !s.ctrl[`ASBS_BIT_WAKE_STANDBY], idle_ev, brk_ev, edge_ev,
            link.done && link.fe, link.done && link.pe};
      next_s.irq_status = next_s.irq_status | ev;
      // Break transmitter; framing detection never looks at this length.
      blen = s.long_break_select ? `ASBS_BRK_LONG : `ASBS_BRK_SHORT;
      // A break starts on a tick, so it lasts whole bit times and a stopped generator sends none.
      if (s.ctrl[`ASBS_BIT_SEND_BREAK] && s.brk_left == 4'h0 && s.ctrl[`ASBS_BIT_TX_ON] &&
          s.tick) begin
         next_s.brk_left = blen + {3'b000, s.ctrl[`ASBS_BIT_NINE_BIT]};
         next_s.brk_sub = 4'h0;
         next_s.ctrl[`ASBS_BIT_SEND_BREAK] = 1'b0;
      end else if (s.tick && s.brk_left != 4'h0) begin
         next_s.brk_sub = s.brk_sub + 4'h1;
         if (s.brk_sub == `ASBS_SMP_END) begin
            next_s.brk_left = s.brk_left - 4'h1;
         end
      end
      next_s.txd = (next_s.brk_left == 4'h0);
      // Read data and answer.
      case (paddr)
         `ASBS_OFS_BAUD_UPPER: rdv[7:0] = {s.break_irq_enable, s.edge_irq_enable, 1'b0,
                                          s.baud_divisor[12:8]};
         `ASBS_OFS_BAUD_LOWER: rdv[7:0] = s.baud_divisor[7:0];
         `ASBS_OFS_STATUS1: rdv[7:0] = {2'b00, s.rx_full_flag, s.idle_flag, 2'b00,
                                       s.framing_error_flag, s.parity_error_flag};
         `ASBS_OFS_STATUS2: rdv[7:0] = {s.break_flag, s.edge_flag, 1'b0, s.receive_invert,
                                       s.wake_idle_select, s.long_break_select, 2'b00};
         `ASBS_OFS_CONTROL: rdv[6:0] = s.ctrl;
         `ASBS_OFS_DATA: rdv[8:0] = s.rx_data;
         `ASBS_OFS_IRQ_STATUS: rdv[5:0] = s.irq_status;
         `ASBS_OFS_IRQ_MASK: rdv[5:0] = s.irq_mask;
         default: rdv = 32'h0000_0000;
      endcase
      next_s.pready = setup;
      if (setup) begin
         next_s.prdata = pwrite ? 32'h0000_0000 : rdv;
         next_s.pslverr = !asbs_mapped(paddr);
      end else if (access) begin
         next_s.prdata = 32'h0000_0000;
         next_s.pslverr = 1'b0;
      end
      next_s.irq = (|(next_s.irq_status & next_s.irq_mask)) ||
                   (next_s.break_irq_enable && next_s.break_flag) ||
                   (next_s.edge_irq_enable && next_s.edge_flag);
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.baud_divisor <= {5'h00, `ASBS_RST_BAUD_LOWER};
         s.sync1 <= 1'b1;
         s.sync2 <= 1'b1;
         s.prev_rx <= 1'b1;
         s.txd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;
   assign txd_pin = s.txd;
endmodule // asbs_top

/* hw/asbs_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the serial block.
// Assumes: Byte addresses on a 32-bit APB, one register per aligned word.
// Notes: Definitions only.
`ifndef ASBS_CFG_SVH
`define ASBS_CFG_SVH
// ==========================================================
// Register offsets
`define ASBS_OFS_BAUD_UPPER 8'h00
`define ASBS_OFS_BAUD_LOWER 8'h04
`define ASBS_OFS_STATUS1 8'h08
`define ASBS_OFS_STATUS2 8'h0c
`define ASBS_OFS_CONTROL 8'h10
`define ASBS_OFS_DATA 8'h14
`define ASBS_OFS_IRQ_STATUS 8'h18
`define ASBS_OFS_IRQ_MASK 8'h1c
// ==========================================================
// Field positions
`define ASBS_BIT_BREAK_IE 7
`define ASBS_BIT_EDGE_IE 6
`define ASBS_BIT_BREAK_FLAG 7
`define ASBS_BIT_EDGE_FLAG 6
`define ASBS_BIT_RX_INVERT 4
`define ASBS_BIT_WAKE_IDLE 3
`define ASBS_BIT_LONG_BREAK 2
`define ASBS_BIT_RX_FULL 5
`define ASBS_BIT_IDLE 4
`define ASBS_BIT_FRAMING 1
`define ASBS_BIT_PARITY 0
`define ASBS_BIT_RX_ON 0
`define ASBS_BIT_TX_ON 1
`define ASBS_BIT_PARITY_ON 2
`define ASBS_BIT_NINE_BIT 3
`define ASBS_BIT_SEND_BREAK 4
`define ASBS_BIT_WAKE_STANDBY 5
`define ASBS_BIT_BREAK_DET 6
// ==========================================================
// Reset values and counts
`define ASBS_RST_BAUD_LOWER 8'h04
`define ASBS_SMP_FIRST 4'h7
`define ASBS_SMP_LAST 4'h9
`define ASBS_SMP_END 4'hf
`define ASBS_BRK_SHORT 4'ha
`define ASBS_BRK_LONG 4'hd
`endif

/* hw/asbs_pkg.sv */
// Purpose: Types shared by the serial block modules.
// Assumes: Constants live in asbs_cfg.svh.
// Notes: None.
package asbs_pkg;
   // ==========================================================
   // Receiver states
   typedef enum logic [2:0] {
      ASBS_RX_IDLE = 3'b000,
      ASBS_RX_START = 3'b001,
      ASBS_RX_DATA = 3'b010,
      ASBS_RX_STOP = 3'b011
   } asbs_rx_st_t;

   typedef struct packed {
      asbs_rx_st_t st;
      logic [3:0] smp;
      logic [3:0] bitn;
      logic [8:0] shreg;
      logic [1:0] ones;
      logic [7:0] idle_cnt;
      logic idle_done;
      logic done;
      logic fe;
      logic pe;
      logic brk;
      logic idle;
      logic [8:0] data;
   } asbs_rx_state_t;

   typedef struct packed {
      logic [4:0] baud_upper_buf;
      logic [12:0] baud_divisor;
      logic break_irq_enable;
      logic edge_irq_enable;
      logic gen_armed;
      logic [12:0] div_cnt;
      logic tick;
      logic [6:0] ctrl;
      logic receive_invert;
      logic wake_idle_select;
      logic long_break_select;
      logic break_flag;
      logic edge_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic framing_error_flag;
      logic parity_error_flag;
      logic [8:0] rx_data;
      logic clear_armed;
      logic [5:0] irq_status;
      logic [5:0] irq_mask;
      logic sync1;
      logic sync2;
      logic prev_rx;
      logic [3:0] brk_left;
      logic [3:0] brk_sub;
      logic txd;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } asbs_top_state_t;
endpackage

/* hw/asbs_if.sv */
// Purpose: Signals between the register block and the receiver.
// Assumes: One clock domain.
// Notes: None.
`timescale 1ns/10ps
interface asbs_if;
   logic tick;
   logic rxd;
   logic rx_on;
   logic parity_on;
   logic nine_bit;
   logic done;
   logic [8:0] data;
   logic fe;
   logic pe;
   logic brk;
   logic idle;
   modport ctl (output tick, rxd, rx_on, parity_on, nine_bit, input done, data, fe, pe, brk, idle);
   modport rx (input tick, rxd, rx_on, parity_on, nine_bit, output done, data, fe, pe, brk, idle);
endinterface

/* hw/asbs_rx.sv */
// Purpose: Serial receiver sampling at sixteen ticks per bit.
// Assumes: Line already synchronised and polarity corrected.
// Notes: Parity, when on, is the last data bit and is even.
`timescale 1ns/10ps
`include "asbs_cfg.svh"
module asbs_rx (
   input wire logic pclk,
   input wire logic presetn,
   asbs_if.rx bus
);
   asbs_pkg::asbs_rx_state_t r;
   asbs_pkg::asbs_rx_state_t next_r;

   function automatic logic [8:0] asbs_field(input logic [8:0] sh, input logic nine);
      asbs_field = nine ? sh : {1'b0, sh[8:1]};
   endfunction

   always_comb begin
      logic bitv;
      logic [8:0] fld;
      next_r = r;
      bitv = r.ones[1];
      fld = asbs_field(r.shreg, bus.nine_bit);
      next_r.done = 1'b0;
      next_r.idle = 1'b0;
      if (bus.tick && bus.rx_on) begin
         if (r.st != asbs_pkg::ASBS_RX_IDLE) begin
            next_r.smp = r.smp + 4'h1;
            if (r.smp >= `ASBS_SMP_FIRST && r.smp <= `ASBS_SMP_LAST) begin
               next_r.ones = r.ones + {1'b0, bus.rxd};
            end
         end
         case (r.st)
            asbs_pkg::ASBS_RX_IDLE: begin
               if (!bus.rxd) begin
                  next_r.st = asbs_pkg::ASBS_RX_START;
                  next_r.smp = 4'h1;
                  next_r.ones = 2'b00;
                  next_r.idle_cnt = 8'h00;
                  next_r.idle_done = 1'b0;
               end else if (!r.idle_done) begin
                  next_r.idle_cnt = r.idle_cnt + 8'h01;
                  if (r.idle_cnt == (bus.nine_bit ? 8'haf : 8'h9f)) begin
                     next_r.idle = 1'b1;
                     next_r.idle_done = 1'b1;
                  end
               end
            end
            asbs_pkg::ASBS_RX_START: begin
               if (r.smp == `ASBS_SMP_END) begin
                  next_r.ones = 2'b00;
                  next_r.bitn = 4'h0;
                  next_r.st = bitv ? asbs_pkg::ASBS_RX_IDLE : asbs_pkg::ASBS_RX_DATA;
               end
            end
            asbs_pkg::ASBS_RX_DATA: begin
               if (r.smp == `ASBS_SMP_END) begin
                  next_r.ones = 2'b00;
                  next_r.shreg = {bitv, r.shreg[8:1]};
                  next_r.bitn = r.bitn + 4'h1;
                  if (r.bitn == (bus.nine_bit ? 4'h8 : 4'h7)) begin
                     next_r.st = asbs_pkg::ASBS_RX_STOP;
                  end
               end
            end
            asbs_pkg::ASBS_RX_STOP: begin
               if (r.smp == `ASBS_SMP_END) begin
                  next_r.ones = 2'b00;
                  next_r.data = fld;
                  next_r.fe = !bitv;
                  next_r.pe = bus.parity_on && (^fld);
                  next_r.brk = (fld == 9'h000) && !bitv;
                  next_r.done = 1'b1;
                  next_r.st = asbs_pkg::ASBS_RX_IDLE;
               end
            end
            default: begin
               next_r.st = asbs_pkg::ASBS_RX_IDLE;
            end
         endcase
      end else if (!bus.rx_on) begin
         next_r.st = asbs_pkg::ASBS_RX_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign bus.done = r.done;
   assign bus.data = r.data;
   assign bus.fe = r.fe;
   assign bus.pe = r.pe;
   assign bus.brk = r.brk;
   assign bus.idle = r.idle;
endmodule // asbs_rx

/* tb/asbs_top_properties.sv */
// Purpose: Port-level checks of the serial baud and status block.
// Assumes: Single clock pclk, reset presetn asynchronous active low.
// Notes: Bound to asbs_top after the module.
`timescale 1ns/10ps
module asbs_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic rxd_pin,
   input wire logic txd_pin
);
   // ==========
   // Helper terms
   logic bad;
   logic [15:0] low_run;
   assign bad = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_run <= 16'h0000;
      end else if (!txd_pin) begin
         low_run <= low_run + 16'h0001;
      end else begin
         low_run <= 16'h0000;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========
   // Assertions
   a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
      else $error("No answer in the access cycle.");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("Answer outside an access cycle.");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("Answer held longer than one cycle.");
   a_err_bad_addr: assert property (psel && penable && pready && bad |-> pslverr)
      else $error("Unmapped address not refused.");
   a_err_good_addr: assert property (pready && !bad |-> !pslverr)
      else $error("Mapped address refused.");
   a_read_bad_zero: assert property (pready && !pwrite && bad |-> prdata == 32'h00000000)
      else $error("Refused read returned data.");
   a_prdata_idle: assert property (!pready |-> prdata == 32'h00000000)
      else $error("Read data outside the access cycle.");
   a_upper_bits_zero: assert property (pready && !pwrite |-> prdata[31:9] == 23'h000000)
      else $error("Unused read bits not zero.");
   a_break_length: assert property ($rose(txd_pin) |-> low_run >= 16'h00a0)
      else $error("Transmit line low for less than a break.");
   c_refused: cover property (pready && pslverr);
   c_break: cover property ($fell(txd_pin));
   c_irq: cover property ($rose(irq));
endmodule // asbs_top_properties

bind asbs_top asbs_top_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .rxd_pin(rxd_pin), .txd_pin(txd_pin));

/* tb/asbs_remote.sv */
// Purpose: Remote serial transceiver on the receive and transmit lines.
// Assumes: Frames are sent on request at a fixed bit time in pclk cycles.
// Notes: Measures the length of each low run on the transmit line.
`timescale 1ns/10ps
module asbs_remote (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [8:0] data,
   input wire logic [3:0] nbits,
   input wire logic stop_bit,
   input wire logic inv,
   input wire logic [15:0] bit_cycles,
   input wire logic tx_line,
   output logic line,
   output logic busy = 1'b0,
   output logic [15:0] low_cycles
);
   logic cur = 1'b1;
   logic [15:0] run;
   assign line = cur ^ inv;
   // ==========
   // Frame sender, start bit, data bits first bit lowest, stop bit.
   always begin
      @(posedge pclk);
      if (start && !busy) begin
         busy <= 1'b1;
         cur <= 1'b0;
         repeat (bit_cycles) @(posedge pclk);
         for (int i = 0; i < nbits; i++) begin
            cur <= data[i];
            repeat (bit_cycles) @(posedge pclk);
         end
         cur <= stop_bit;
         repeat (bit_cycles) @(posedge pclk);
         cur <= 1'b1;
         busy <= 1'b0;
      end
   end
   // ==========
   // Low run meter on the transmit line.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 16'h0000;
         low_cycles <= 16'h0000;
      end else if (!tx_line) begin
         run <= run + 16'h0001;
      end else if (run != 16'h0000) begin
         low_cycles <= run;
         run <= 16'h0000;
      end
   end
endmodule // asbs_remote

/* tb/test_async_serial_baud_status.sv */
// Purpose: Self-checking bench of the serial baud and status block.
// Assumes: Zero-wait APB; the divisor is set to DIV during the run.
// Notes: The remote model drives the receive pin and meters breaks.
`timescale 1ns/10ps
module test_async_serial_baud_status;
   localparam int DIV = 2;
   typedef struct packed {logic w; logic [7:0] a, d, m, e; logic err;} asbs_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rxd_pin, txd_pin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic r_start, r_stop, r_inv, r_busy, err;
   logic [8:0] r_data;
   logic [15:0] low_cycles;
   int failures, check_count, cycles, lows;
   asbs_row_t rows [24] = '{
      '{1'b0, 8'h00, 8'h00, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'hff, 8'h04, 1'b0},
      '{1'b0, 8'h1c, 8'h00, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h18, 8'h00, 8'hff, 8'h00, 1'b0},
      '{1'b1, 8'h00, 8'hc1, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'hff, 8'hc0, 1'b0},
      '{1'b1, 8'h04, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'hff, 8'hc1, 1'b0},
      '{1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'hff, 8'h01, 1'b0},
      '{1'b1, 8'h04, 8'h02, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'hff, 8'h02, 1'b0},
      '{1'b0, 8'h00, 8'h00, 8'hff, 8'h00, 1'b0}, '{1'b1, 8'h0c, 8'h1c, 8'h00, 8'h00, 1'b0},
      '{1'b0, 8'h0c, 8'h00, 8'hff, 8'h1c, 1'b0}, '{1'b1, 8'h0c, 8'h00, 8'h00, 8'h00, 1'b0},
      '{1'b1, 8'h1c, 8'h3f, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h1c, 8'h00, 8'hff, 8'h3f, 1'b0},
      '{1'b1, 8'h1c, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h20, 8'h00, 8'hff, 8'h00, 1'b1},
      '{1'b0, 8'h06, 8'h00, 8'hff, 8'h00, 1'b1}, '{1'b1, 8'h24, 8'hff, 8'h00, 8'h00, 1'b1},
      '{1'b1, 8'h10, 8'h41, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'hff, 8'h41, 1'b0}};
   asbs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .rxd_pin(rxd_pin), .txd_pin(txd_pin));
   asbs_remote u_remote (.pclk(pclk), .presetn(presetn), .start(r_start), .data(r_data),
      .nbits(4'h8), .stop_bit(r_stop), .inv(r_inv), .bit_cycles(16'(16 * DIV)),
      .tx_line(txd_pin), .line(rxd_pin), .busy(r_busy), .low_cycles(low_cycles));
   // ==========
   // Clock, timeout and shared tasks
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd & {24'h000000, m}, {24'h000000, e});
   endtask
   task automatic frame(input logic [8:0] d, input logic s);
      {r_data, r_stop, r_start} <= {d, s, 1'b1};
      @(posedge pclk);
      r_start <= 1'b0;
      do begin
         @(posedge pclk);
      end while (r_busy === 1'b1);
      repeat (48) @(posedge pclk);
   endtask
   task automatic wait_txd(input logic v);
      while (txd_pin !== v) begin
         @(posedge pclk);
      end
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, v});
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========
   // Main sequence
   initial begin
      {pclk, presetn, failures, check_count, cycles} = '0;
      {psel, penable, pwrite, paddr, pwdata, r_start, r_stop, r_inv, r_data} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 24; k++) begin
         apb(rows[k].w, rows[k].a, rows[k].d);
         if (!rows[k].w) chk(rd & {24'h000000, rows[k].m}, {24'h000000, rows[k].e});
         chk({31'h0, err}, {31'h0, rows[k].err});
      end
      $display("test registers done");
      frame(9'h0a5, 1'b1);
      rdc(8'h08, 8'h23, 8'h20);
      rdc(8'h14, 8'hff, 8'ha5);
      rdc(8'h08, 8'h23, 8'h00);
      rdc(8'h0c, 8'h40, 8'h40);
      rdc(8'h18, 8'h20, 8'h20);
      wr(8'h1c, 8'h20);
      irq_is(1'b1);
      wr(8'h18, 8'h20);
      irq_is(1'b0);
      wr(8'h1c, 8'h00);
      frame(9'h055, 1'b0);
      rdc(8'h08, 8'h23, 8'h22);
      rdc(8'h14, 8'hff, 8'h55);
      wr(8'h10, 8'h45);
      frame(9'h001, 1'b1);
      rdc(8'h08, 8'h23, 8'h21);
      rdc(8'h14, 8'hff, 8'h01);
      frame(9'h081, 1'b1);
      rdc(8'h08, 8'h23, 8'h20);
      rdc(8'h14, 8'hff, 8'h81);
      wr(8'h10, 8'h41);
      wr(8'h00, 8'h80);
      frame(9'h000, 1'b0);
      rdc(8'h0c, 8'h80, 8'h80);
      irq_is(1'b1);
      wr(8'h00, 8'h00);
      irq_is(1'b0);
      wr(8'h0c, 8'h80);
      rdc(8'h0c, 8'h80, 8'h00);
      rdc(8'h08, 8'h22, 8'h22);
      rdc(8'h14, 8'hff, 8'h00);
      $display("test receive done");
      wr(8'h0c, 8'h14);
      wr(8'h0c, 8'h54);
      r_inv <= 1'b1;
      repeat (64) @(posedge pclk);
      rdc(8'h0c, 8'h40, 8'h00);
      wr(8'h00, 8'h40);
      frame(9'h03c, 1'b1);
      rdc(8'h0c, 8'h40, 8'h40);
      irq_is(1'b1);
      rdc(8'h08, 8'h23, 8'h20);
      rdc(8'h14, 8'hff, 8'h3c);
      r_inv <= 1'b0;
      repeat (8) @(posedge pclk);
      wr(8'h0c, 8'h40);
      wr(8'h00, 8'h00);
      irq_is(1'b0);
      $display("test edge done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h0c, i[0] ? 8'h04 : 8'h00);
         wr(8'h10, i[1] ? 8'h1b : 8'h13);
         wait_txd(1'b0);
         wait_txd(1'b1);
         repeat (2) @(posedge pclk);
         chk({16'h0000, low_cycles}, 32'((10 + 3 * i[0] + i[1]) * 16 * DIV));
      end
      wr(8'h04, 8'h00);
      wr(8'h10, 8'h13);
      lows = 0;
      repeat (600) @(posedge pclk) lows += (txd_pin !== 1'b1);
      chk(32'(lows), 32'h00000000);
      wr(8'h10, 8'h41);
      wr(8'h04, 8'h02);
      $display("test break done");
      for (int j = 0; j < 2; j++) begin
         apb(1'b0, 8'h08, 8'h00);
         apb(1'b0, 8'h14, 8'h00);
         wr(8'h0c, j ? 8'h08 : 8'h00);
         wr(8'h10, 8'h61);
         frame(9'h011, 1'b1);
         repeat (12 * 16 * DIV) @(posedge pclk);
         rdc(8'h08, 8'h30, j ? 8'h10 : 8'h00);
      end
      $display("test idle done");
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h04, 8'hff, 8'h04);
      rdc(8'h10, 8'hff, 8'h00);
      chk({31'h0, txd_pin}, 32'h00000001);
      $display("test reset done");
      finish_test();
   end
endmodule // test_async_serial_baud_status
